// [plmx_pins_model.sv]
// board-side model of the port pins: pull-ups, external pull-downs, analog sources
`default_nettype none
module plmx_pins_model
(
    input  wire logic [7:0] i_adrh_pin,
    input  wire logic [7:0] i_adrh_oe_n,
    input  wire logic [7:0] i_ctrl_pin,
    input  wire logic [7:0] i_ctrl_oe_n,
    input  wire logic [7:0] i_ain_board,
    input  wire logic [7:0] i_adrh_pull_low,
    input  wire logic [7:0] i_ctrl_pull_low,
    output logic      [7:0] o_ain_level,
    output logic      [7:0] o_adrh_level,
    output logic      [7:0] o_ctrl_level
);
    timeunit 1ns;
    timeprecision 100ps;
    // analog-input pins only ever see the board level, never a device driver
    assign o_ain_level  = i_ain_board;
    // a driven bit shows the device value; an undriven bit floats to the pull-up
    // unless the board pulls it low (tests never fight a driven high)
    assign o_adrh_level = (~i_adrh_oe_n & i_adrh_pin)
                        | (i_adrh_oe_n & ~i_adrh_pull_low);
    assign o_ctrl_level = (~i_ctrl_oe_n & i_ctrl_pin)
                        | (i_ctrl_oe_n & ~i_ctrl_pull_low);
endmodule
`default_nettype wire

// [plmx_pkg.sv]
// package for the port latch and pin mux block: addresses, reset values, opcodes
`default_nettype none
package plmx_pkg;
    localparam int          PORT_W          = 8;
    localparam logic [7:0]  ADDR_AIN_PORT   = 8'h90;
    localparam logic [7:0]  ADDR_ADRH_PORT  = 8'hA0;
    localparam logic [7:0]  ADDR_CTRL_PORT  = 8'hB0;
    localparam logic [7:0]  LATCH_RESET     = 8'hFF;
    // bit positions on the address-high port
    localparam int          BIT_SPI_CLK     = 0;
    localparam int          BIT_SPI_MOSI    = 1;
    localparam int          BIT_SPI_MISO    = 2;
    localparam int          BIT_SPI_SS      = 3;
    localparam int          BIT_T2X         = 4;
    localparam int          BIT_PW_A        = 5;
    localparam int          BIT_PW_B        = 6;
    localparam int          BIT_PW_CLK      = 7;
    // bit positions on the control-signal port
    localparam int          BIT_RXD         = 0;
    localparam int          BIT_TXD         = 1;
    localparam int          BIT_INT0        = 2;
    localparam int          BIT_IRQ1        = 3;
    localparam int          BIT_CNT0        = 4;
    localparam int          BIT_CNT1        = 5;
    localparam int          BIT_WR          = 6;
    localparam int          BIT_RD          = 7;
    // access kinds presented by the cpu with each port access
    typedef enum logic [3:0]
    {
        PLMX_OP_PLAIN_READ,
        PLMX_OP_MOVE_WRITE,
        PLMX_OP_AND,
        PLMX_OP_OR,
        PLMX_OP_XOR,
        PLMX_OP_JUMP_SET_CLEAR,
        PLMX_OP_COMPLEMENT,
        PLMX_OP_INC,
        PLMX_OP_DEC,
        PLMX_OP_DEC_JUMP_NZ,
        PLMX_OP_MOVE_CARRY_BIT,
        PLMX_OP_CLEAR_BIT,
        PLMX_OP_SET_BIT
    } plmx_op_type;
endpackage
`default_nettype wire

// [plmx_sync.sv]
// two-flop synchroniser for a vector of pin inputs
`default_nettype none
module plmx_sync
#(
    parameter int WIDTH = 8
)
(
    input  wire logic             i_core_clk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage1;

    // first stage feeds only the second; reset to idle-high like a pulled-up pin
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            stage1 <= '1;
            o_sync <= '1;
        end
        else
        begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule
`default_nettype wire

// [plmx_top.sv]
// three port latches with pin muxing and read-modify-write operand selection
// Notes on behaviour
// RULE_01: analog-input port latch, 8 bits, read/write at 90H.
// RULE_02: analog-input port pins are never driven as digital outputs.
// RULE_03: analog-input latch bits reset to 1, meaning analog use.
// RULE_04: latch bit 0 makes that pin a readable high-impedance digital input.
// RULE_05: bidirectional pin with latch 1 is only pulled up, usable as input.
// RULE_06: address-high port pin with latch 0 drives low.
// RULE_07: external data access puts middle/high address bytes on address-high port.
// RULE_08: selected pulse-width outputs drive bits 5 and 6, overriding the latch.
// RULE_09: address-high bit 7 may feed the pulse-width generator clock.
// RULE_10: bits 0-4 route to spi clock/mosi/miso, select/timer-2 clock, timer-2 control.
// RULE_11: control-signal port latch, 8 bits, pull-ups, at B0H.
// RULE_12: control-signal pin with latch 0 drives low; latch 1 only pulls up.
// RULE_13: control alternate functions act only while latch is 1; else pin low.
// RULE_14: bit 0 serial receive or mode-0 data; bit 1 transmit or shift clock.
// RULE_15: bits 2 and 3 feed external interrupts 0 and 1.
// RULE_16: bits 4 and 5 feed counter inputs of timers 0 and 1.
// RULE_17: bits 6 and 7 carry external data write and read strobes.
// RULE_18: plain reads of a port sample the pin level.
// RULE_19: read-modify-write with port destination reads the latch.
// RULE_20: and, or, xor, jump-clear, complement, inc, dec, dec-jump, bit moves are rmw.
// RULE_21: single-bit writes read whole latch, change one bit, write byte back.
// RULE_22: each bit offers a latch read path and a pin read path.
// RULE_23: pin inputs pass a two-stage synchroniser before use.
`default_nettype none
module plmx_top
    import plmx_pkg::*;
(
    input  wire logic              i_core_clk,
    input  wire logic              i_rst_n,
    // special function register access from the cpu
    input  wire logic              i_sfr_rd,
    input  wire logic              i_sfr_wr,
    input  wire logic [7:0]        i_sfr_addr,
    input  wire logic [7:0]        i_sfr_wdata,
    input  wire plmx_op_type       i_sfr_op,
    input  wire logic [2:0]        i_sfr_bit,
    output logic      [7:0]        o_sfr_rdata,
    // external pins (oe low = driving the pin value; control port drives only lows)
    input  wire logic [7:0]        i_ain_pin,
    input  wire logic [7:0]        i_adrh_pin,
    output logic      [7:0]        o_adrh_pin,
    output logic      [7:0]        o_adrh_oe_n,
    input  wire logic [7:0]        i_ctrl_pin,
    output logic      [7:0]        o_ctrl_pin,
    output logic      [7:0]        o_ctrl_oe_n,
    // external data memory
    input  wire logic              i_xdata_active,
    input  wire logic [7:0]        i_xdata_addr_mid,
    input  wire logic [7:0]        i_xdata_addr_high,
    input  wire logic              i_xdata_addr_sel_high,
    input  wire logic              i_xdata_wr_n,
    input  wire logic              i_xdata_rd_n,
    // pulse-width generator
    input  wire logic              i_pw_select,
    input  wire logic              i_pulse_width_out_a,
    input  wire logic              i_pulse_width_out_b,
    output logic                   o_pulse_width_ext_clock,
    // spi
    input  wire logic              i_spi_master,
    input  wire logic              i_spi_enable,
    input  wire logic              i_spi_clk_out,
    input  wire logic              i_spi_mosi_out,
    input  wire logic              i_spi_miso_out,
    output logic                   o_serial_peripheral_clock_pin,
    output logic                   o_spi_mosi_in,
    output logic                   o_spi_miso_in,
    output logic                   o_spi_ss_n,
    output logic                   o_timer_two_count_input,
    output logic                   o_timer_two_external_control,
    // uart
    input  wire logic              i_uart_mode0,
    input  wire logic              i_uart_data_out,
    input  wire logic              i_uart_txd_out,
    output logic                   o_uart_rxd,
    output logic                   o_external_interrupt_zero,
    output logic                   o_external_interrupt_one,
    output logic                   o_counter_zero_input,
    output logic                   o_counter_one_input,
    // analog use per pin (1 = analog)
    output logic      [7:0]        o_ain_analog_sel
);
    logic [7:0] ain_latch;
    logic [7:0] adrh_latch;
    logic [7:0] ctrl_latch;
    logic [7:0] ain_sync;
    logic [7:0] adrh_sync;
    logic [7:0] ctrl_sync;

    // pin levels come from another domain, so resample before any logic
    plmx_sync #(.WIDTH(PORT_W)) u_sync_ain
    (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_async    (i_ain_pin),
        .o_sync     (ain_sync)
    ); // [RULE_23]
    plmx_sync #(.WIDTH(PORT_W)) u_sync_adrh
    (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_async    (i_adrh_pin),
        .o_sync     (adrh_sync)
    ); // [RULE_23]
    plmx_sync #(.WIDTH(PORT_W)) u_sync_ctrl
    (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_async    (i_ctrl_pin),
        .o_sync     (ctrl_sync)
    ); // [RULE_23]

    // classify the access; only listed kinds take the latch as operand
    function automatic logic is_rmw(input plmx_op_type op);
        case (op)
            PLMX_OP_AND, PLMX_OP_OR, PLMX_OP_XOR, PLMX_OP_JUMP_SET_CLEAR,
            PLMX_OP_COMPLEMENT, PLMX_OP_INC, PLMX_OP_DEC, PLMX_OP_DEC_JUMP_NZ,
            PLMX_OP_MOVE_CARRY_BIT, PLMX_OP_CLEAR_BIT, PLMX_OP_SET_BIT:
                is_rmw = 1'b1; // [RULE_20]
            default:
                is_rmw = 1'b0;
        endcase
    endfunction

    function automatic logic is_bit_op(input plmx_op_type op);
        is_bit_op = (op == PLMX_OP_MOVE_CARRY_BIT) || (op == PLMX_OP_CLEAR_BIT)
                 || (op == PLMX_OP_SET_BIT) || (op == PLMX_OP_JUMP_SET_CLEAR)
                 || (op == PLMX_OP_COMPLEMENT);
    endfunction

    // address decode
    wire sel_ain  = (i_sfr_addr == ADDR_AIN_PORT);  // [RULE_01]
    wire sel_adrh = (i_sfr_addr == ADDR_ADRH_PORT);
    wire sel_ctrl = (i_sfr_addr == ADDR_CTRL_PORT); // [RULE_11]
    wire rmw_op   = is_rmw(i_sfr_op);
    wire bit_op   = is_bit_op(i_sfr_op);

    // latch read path versus pin read path for each port
    wire [7:0] ain_view  = rmw_op ? ain_latch  : ain_sync;  // [RULE_18] [RULE_19] [RULE_22]
    wire [7:0] adrh_view = rmw_op ? adrh_latch : adrh_sync; // [RULE_18] [RULE_19] [RULE_22]
    wire [7:0] ctrl_view = rmw_op ? ctrl_latch : ctrl_sync; // [RULE_18] [RULE_19] [RULE_22]
    wire [7:0] next_rdata = sel_ain  ? ain_view  :
                            sel_adrh ? adrh_view :
                            sel_ctrl ? ctrl_view : 8'h00;

    // single-bit writes merge one bit of wdata into the current latch byte
    wire [7:0] bit_mask = 8'h01 << i_sfr_bit;
    wire [7:0] cur_latch = sel_ain ? ain_latch : sel_adrh ? adrh_latch : ctrl_latch;
    wire [7:0] next_latch = bit_op ? ((cur_latch & ~bit_mask) | (i_sfr_wdata & bit_mask))
                                   : i_sfr_wdata; // [RULE_21]

    // latches; all bits come up high
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            ain_latch  <= LATCH_RESET; // [RULE_03]
            adrh_latch <= LATCH_RESET;
            ctrl_latch <= LATCH_RESET;
        end
        else if (i_sfr_wr)
        begin
            if (sel_ain)
                ain_latch <= next_latch;  // [RULE_01] [RULE_21]
            if (sel_adrh)
                adrh_latch <= next_latch;
            if (sel_ctrl)
                ctrl_latch <= next_latch; // [RULE_11] [RULE_21]
        end
    end

    // read data registered, held between reads
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
            o_sfr_rdata <= 8'h00;
        else if (i_sfr_rd)
            o_sfr_rdata <= next_rdata;
    end

    // address-high port output value: external address, pulse-width, spi, else latch
    logic [7:0] adrh_val;
    logic [7:0] adrh_drive;
    always_comb
    begin
        adrh_val   = adrh_latch;
        adrh_drive = ~adrh_latch; // latch 0 drives low, 1 only pulled up [RULE_05] [RULE_06]
        if (i_xdata_active)
        begin
            adrh_val   = i_xdata_addr_sel_high ? i_xdata_addr_high : i_xdata_addr_mid; // [RULE_07]
            adrh_drive = 8'hFF;
        end
        else
        begin
            if (i_pw_select)
            begin
                adrh_val[BIT_PW_A]   = i_pulse_width_out_a; // [RULE_08]
                adrh_val[BIT_PW_B]   = i_pulse_width_out_b; // [RULE_08]
                adrh_drive[BIT_PW_A] = 1'b1;
                adrh_drive[BIT_PW_B] = 1'b1;
            end
            if (i_spi_enable)
            begin
                if (i_spi_master)
                begin
                    adrh_val[BIT_SPI_CLK]    = i_spi_clk_out;  // [RULE_10]
                    adrh_val[BIT_SPI_MOSI]   = i_spi_mosi_out; // [RULE_10]
                    adrh_drive[BIT_SPI_CLK]  = 1'b1;
                    adrh_drive[BIT_SPI_MOSI] = 1'b1;
                end
                else
                begin
                    adrh_val[BIT_SPI_MISO]   = i_spi_miso_out; // [RULE_10]
                    adrh_drive[BIT_SPI_MISO] = 1'b1;
                end
            end
        end
    end

    // control-signal port: alternates gated by latch bit, latch 0 forces low
    logic [7:0] ctrl_alt;
    always_comb
    begin
        ctrl_alt          = 8'hFF;
        ctrl_alt[BIT_RXD] = i_uart_mode0 ? i_uart_data_out : 1'b1;  // [RULE_14]
        ctrl_alt[BIT_TXD] = i_uart_txd_out;                         // [RULE_14]
        ctrl_alt[BIT_WR]  = i_xdata_active ? i_xdata_wr_n : 1'b1;   // [RULE_17]
        ctrl_alt[BIT_RD]  = i_xdata_active ? i_xdata_rd_n : 1'b1;   // [RULE_17]
    end
    wire [7:0] ctrl_val = ctrl_latch & ctrl_alt; // [RULE_12] [RULE_13]

    // pin drivers registered so outputs come straight from flops
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            o_adrh_pin  <= 8'hFF;
            o_adrh_oe_n <= 8'hFF;
            o_ctrl_pin  <= 8'hFF;
            o_ctrl_oe_n <= 8'hFF;
        end
        else
        begin
            o_adrh_pin  <= adrh_val;
            o_adrh_oe_n <= ~(adrh_drive & ~(adrh_val & ~adrh_drive)); // [RULE_06]
            o_ctrl_pin  <= ctrl_val;
            o_ctrl_oe_n <= ctrl_val; // drive only lows, highs rely on pull-up [RULE_12]
        end
    end

    // alternate inputs to peripherals; control ones masked by latch bit
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            o_ain_analog_sel              <= LATCH_RESET;
            o_pulse_width_ext_clock       <= 1'b1;
            o_serial_peripheral_clock_pin <= 1'b1;
            o_spi_mosi_in                 <= 1'b1;
            o_spi_miso_in                 <= 1'b1;
            o_spi_ss_n                    <= 1'b1;
            o_timer_two_count_input       <= 1'b1;
            o_timer_two_external_control  <= 1'b1;
            o_uart_rxd                    <= 1'b1;
            o_external_interrupt_zero     <= 1'b1;
            o_external_interrupt_one      <= 1'b1;
            o_counter_zero_input          <= 1'b1;
            o_counter_one_input           <= 1'b1;
        end
        else
        begin
            o_ain_analog_sel              <= ain_latch;                 // [RULE_03] [RULE_04]
            o_pulse_width_ext_clock       <= adrh_sync[BIT_PW_CLK];     // [RULE_09]
            o_serial_peripheral_clock_pin <= adrh_sync[BIT_SPI_CLK];    // [RULE_10]
            o_spi_mosi_in                 <= adrh_sync[BIT_SPI_MOSI];   // [RULE_10]
            o_spi_miso_in                 <= adrh_sync[BIT_SPI_MISO];   // [RULE_10]
            o_spi_ss_n                    <= adrh_sync[BIT_SPI_SS];     // [RULE_10]
            o_timer_two_count_input       <= adrh_sync[BIT_SPI_SS];     // [RULE_10]
            o_timer_two_external_control  <= adrh_sync[BIT_T2X];        // [RULE_10]
            o_uart_rxd                    <= ctrl_sync[BIT_RXD] & ctrl_latch[BIT_RXD];   // [RULE_14]
            o_external_interrupt_zero     <= ctrl_sync[BIT_INT0] & ctrl_latch[BIT_INT0]; // [RULE_15]
            o_external_interrupt_one      <= ctrl_sync[BIT_IRQ1] & ctrl_latch[BIT_IRQ1]; // [RULE_15]
            o_counter_zero_input          <= ctrl_sync[BIT_CNT0] & ctrl_latch[BIT_CNT0]; // [RULE_16]
            o_counter_one_input           <= ctrl_sync[BIT_CNT1] & ctrl_latch[BIT_CNT1]; // [RULE_16]
        end
    end

    // analog-input port has no output driver at all, by construction [RULE_02]

    // assertions
    property p_rst_latch;
        @(posedge i_core_clk) !i_rst_n |=> (ain_latch == LATCH_RESET);
    endproperty
    a_rst_latch: assert property (p_rst_latch) else $error("latch not ones after reset"); // [RULE_03]

    property p_plain_read_pin;
        @(posedge i_core_clk) disable iff (!i_rst_n)
            (i_sfr_rd && sel_ctrl && !rmw_op) |=> (o_sfr_rdata == $past(ctrl_sync));
    endproperty
    a_plain_read_pin: assert property (p_plain_read_pin) else $error("plain read not pin"); // [RULE_18]

    property p_rmw_read_latch;
        @(posedge i_core_clk) disable iff (!i_rst_n)
            (i_sfr_rd && sel_ain && rmw_op) |=> (o_sfr_rdata == $past(ain_latch));
    endproperty
    a_rmw_read_latch: assert property (p_rmw_read_latch) else $error("rmw read not latch"); // [RULE_19]

    sequence s_bit_write;
        i_sfr_wr && sel_ctrl && (i_sfr_op == PLMX_OP_SET_BIT);
    endsequence
    property p_set_bit;
        @(posedge i_core_clk) disable iff (!i_rst_n)
            s_bit_write |=> ((ctrl_latch & ~$past(bit_mask)) == ($past(ctrl_latch) & ~$past(bit_mask)));
    endproperty
    a_set_bit: assert property (p_set_bit) else $error("bit write disturbed other bits"); // [RULE_21]

    property p_ctrl_low;
        @(posedge i_core_clk) disable iff (!i_rst_n)
            (ctrl_latch[BIT_TXD] == 1'b0) |=> (o_ctrl_pin[BIT_TXD] == 1'b0 && !o_ctrl_oe_n[BIT_TXD]);
    endproperty
    a_ctrl_low: assert property (p_ctrl_low) else $error("control pin not low"); // [RULE_13]

    property p_adrh_low;
        @(posedge i_core_clk) disable iff (!i_rst_n)
            (!i_xdata_active && !i_spi_enable && !i_pw_select && !adrh_latch[BIT_PW_CLK])
            |=> (!o_adrh_oe_n[BIT_PW_CLK] && !o_adrh_pin[BIT_PW_CLK]);
    endproperty
    a_adrh_low: assert property (p_adrh_low) else $error("address-high pin not low"); // [RULE_06]

    property p_pw_override;
        @(posedge i_core_clk) disable iff (!i_rst_n)
            (!i_xdata_active && i_pw_select) |=> (o_adrh_pin[BIT_PW_A] == $past(i_pulse_width_out_a));
    endproperty
    a_pw_override: assert property (p_pw_override) else $error("pulse-width not on pin"); // [RULE_08]

    property p_xaddr;
        @(posedge i_core_clk) disable iff (!i_rst_n)
            (i_xdata_active && i_xdata_addr_sel_high) |=> (o_adrh_pin == $past(i_xdata_addr_high));
    endproperty
    a_xaddr: assert property (p_xaddr) else $error("address byte not on port"); // [RULE_07]
endmodule
`default_nettype wire

// [plmx_top_bench.sv]
// self-checking bench for the port latch and pin mux block
`default_nettype none
module plmx_top_bench
    import plmx_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk;
    logic        rst_n;
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    plmx_op_type op;
    logic [2:0]  bitn;
    logic [7:0]  ain_board, adrh_pull, ctrl_pull, x_mid, x_high;
    logic        x_act, x_sel, x_wr_n, x_rd_n, pw_sel, pw_a, pw_b;
    logic        spi_m, spi_en, spi_clk, spi_mosi, spi_miso, u_m0, u_data, u_txd;
    wire  [7:0]  rdata, adrh_pin, adrh_oe_n, ctrl_pin, ctrl_oe_n, ain_sel;
    wire  [7:0]  ain_lvl, adrh_lvl, ctrl_lvl;
    wire         pw_clk, sclk, mosi_in, miso_in, ss_n, t2c, t2x, rxd, ei0, ei1, c0, c1;
    int          n_mismatch;
    int          tests_run;

    plmx_top plmx_top_i (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_sfr_rd(rd), .i_sfr_wr(wr),
        .i_sfr_addr(addr), .i_sfr_wdata(wdata), .i_sfr_op(op), .i_sfr_bit(bitn),
        .o_sfr_rdata(rdata), .i_ain_pin(ain_lvl), .i_adrh_pin(adrh_lvl),
        .o_adrh_pin(adrh_pin), .o_adrh_oe_n(adrh_oe_n), .i_ctrl_pin(ctrl_lvl),
        .o_ctrl_pin(ctrl_pin), .o_ctrl_oe_n(ctrl_oe_n), .i_xdata_active(x_act),
        .i_xdata_addr_mid(x_mid), .i_xdata_addr_high(x_high), .i_xdata_addr_sel_high(x_sel),
        .i_xdata_wr_n(x_wr_n), .i_xdata_rd_n(x_rd_n), .i_pw_select(pw_sel),
        .i_pulse_width_out_a(pw_a), .i_pulse_width_out_b(pw_b),
        .o_pulse_width_ext_clock(pw_clk), .i_spi_master(spi_m), .i_spi_enable(spi_en),
        .i_spi_clk_out(spi_clk), .i_spi_mosi_out(spi_mosi), .i_spi_miso_out(spi_miso),
        .o_serial_peripheral_clock_pin(sclk), .o_spi_mosi_in(mosi_in), .o_spi_miso_in(miso_in),
        .o_spi_ss_n(ss_n), .o_timer_two_count_input(t2c), .o_timer_two_external_control(t2x),
        .i_uart_mode0(u_m0), .i_uart_data_out(u_data), .i_uart_txd_out(u_txd),
        .o_uart_rxd(rxd), .o_external_interrupt_zero(ei0), .o_external_interrupt_one(ei1),
        .o_counter_zero_input(c0), .o_counter_one_input(c1), .o_ain_analog_sel(ain_sel));

    plmx_pins_model plmx_pins_model_i (
        .i_adrh_pin(adrh_pin), .i_adrh_oe_n(adrh_oe_n), .i_ctrl_pin(ctrl_pin),
        .i_ctrl_oe_n(ctrl_oe_n), .i_ain_board(ain_board), .i_adrh_pull_low(adrh_pull),
        .i_ctrl_pull_low(ctrl_pull), .o_ain_level(ain_lvl), .o_adrh_level(adrh_lvl),
        .o_ctrl_level(ctrl_lvl));

    // 40 MHz core clock
    always #12.5 clk = ~clk;

    // every task enters and leaves 2 ns after a rising edge, so inputs never race it
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d,
                             input plmx_op_type k, input logic [2:0] b);
        addr  = a;
        wdata = d;
        op    = k;
        bitn  = b;
        wr    = 1'b1;
        tick(1);
        wr    = 1'b0;
    endtask

    // read data is registered: it is settled just after the edge that took the strobe
    task automatic expect_rd(input string name, input logic [7:0] a,
                             input plmx_op_type k, input logic [7:0] exp);
        addr = a;
        op   = k;
        rd   = 1'b1;
        tick(1);
        rd   = 1'b0;
        tick(1);
        check(name, rdata, exp);
    endtask

    task automatic conclude();
        $display("checks run %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // a hung run is cut short here and counted as a failure
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        conclude();
    end

    initial
    begin
        clk = 1'b0; rst_n = 1'b0; rd = 1'b0; wr = 1'b0; addr = 8'h00; wdata = 8'h00;
        op = PLMX_OP_PLAIN_READ; bitn = 3'h0; ain_board = 8'h00; adrh_pull = 8'h00;
        ctrl_pull = 8'h00; x_mid = 8'h00; x_high = 8'h00; x_act = 1'b0; x_sel = 1'b0;
        x_wr_n = 1'b1; x_rd_n = 1'b1; pw_sel = 1'b0; pw_a = 1'b0; pw_b = 1'b0;
        spi_m = 1'b0; spi_en = 1'b0; spi_clk = 1'b0; spi_mosi = 1'b0; spi_miso = 1'b1;
        u_m0 = 1'b0; u_data = 1'b1; u_txd = 1'b1; n_mismatch = 0; tests_run = 0;
        tick(6);
        rst_n = 1'b1;
        tick(1);
        // reset state: latches all ones, nothing driven
        expect_rd("ain latch rst", ADDR_AIN_PORT, PLMX_OP_OR, LATCH_RESET);
        check("ain analog rst", ain_sel, 8'hFF);
        check("adrh oe rst", adrh_oe_n, 8'hFF);
        check("ctrl oe rst", ctrl_oe_n, 8'hFF);
        // analog-input port: latch and pin paths differ
        ain_board = 8'h3C;
        sfr_write(ADDR_AIN_PORT, 8'h5A, PLMX_OP_MOVE_WRITE, 3'h0);
        tick(4);
        expect_rd("ain latch", ADDR_AIN_PORT, PLMX_OP_AND, 8'h5A);
        check("ain analog sel", ain_sel, 8'h5A);
        expect_rd("ain pin", ADDR_AIN_PORT, PLMX_OP_PLAIN_READ, 8'h3C);
        // unmapped address: write dropped, read zero
        sfr_write(8'h91, 8'h00, PLMX_OP_MOVE_WRITE, 3'h0);
        expect_rd("unmapped", 8'h91, PLMX_OP_PLAIN_READ, 8'h00);
        expect_rd("ain kept", ADDR_AIN_PORT, PLMX_OP_INC, 8'h5A);
        // address-high port: zeros drive low, ones only pulled
        adrh_pull = 8'h01;
        sfr_write(ADDR_ADRH_PORT, 8'h0F, PLMX_OP_MOVE_WRITE, 3'h0);
        tick(4);
        check("adrh oe", adrh_oe_n, 8'h0F);
        check("adrh level", adrh_lvl, 8'h0E);
        expect_rd("adrh pin", ADDR_ADRH_PORT, PLMX_OP_PLAIN_READ, 8'h0E);
        expect_rd("adrh latch", ADDR_ADRH_PORT, PLMX_OP_DEC, 8'h0F);
        adrh_pull = 8'h00;
        // every read-modify-write kind reads the latch, plain read the pin
        sfr_write(ADDR_CTRL_PORT, 8'hFF, PLMX_OP_MOVE_WRITE, 3'h0);
        ctrl_pull = 8'h0F;
        tick(4);
        for (int k = PLMX_OP_AND; k <= PLMX_OP_SET_BIT; k++)
            expect_rd("rmw latch", ADDR_CTRL_PORT, plmx_op_type'(k), 8'hFF);
        expect_rd("ctrl pin", ADDR_CTRL_PORT, PLMX_OP_PLAIN_READ, 8'hF0);
        ctrl_pull = 8'h00;
        // bit writes change only the addressed bit of the latch byte
        sfr_write(ADDR_CTRL_PORT, 8'h00, PLMX_OP_CLEAR_BIT, 3'h3);
        expect_rd("bit clear", ADDR_CTRL_PORT, PLMX_OP_XOR, 8'hF7);
        sfr_write(ADDR_CTRL_PORT, 8'h08, PLMX_OP_SET_BIT, 3'h3);
        expect_rd("bit set", ADDR_CTRL_PORT, PLMX_OP_XOR, 8'hFF);
        sfr_write(ADDR_CTRL_PORT, 8'h00, PLMX_OP_MOVE_CARRY_BIT, 3'h0);
        expect_rd("bit carry", ADDR_CTRL_PORT, PLMX_OP_XOR, 8'hFE);
        // control port zeros: pins low, alternate inputs held low
        sfr_write(ADDR_CTRL_PORT, 8'h00, PLMX_OP_MOVE_WRITE, 3'h0);
        tick(4);
        check("ctrl low", ctrl_lvl, 8'h00);
        check("ctrl oe low", ctrl_oe_n, 8'h00);
        check("ctrl alt gated", {4'h0, c1, c0, ei1, ei0}, 8'h00);
        sfr_write(ADDR_CTRL_PORT, 8'hFF, PLMX_OP_MOVE_WRITE, 3'h0);
        tick(4);
        check("ctrl high", ctrl_lvl, 8'hFF);
        // interrupts and counters follow their own pins
        for (int b = 2; b < 6; b++)
        begin
            ctrl_pull = 8'h01 << b;
            tick(4);
            check("ctrl alt in", {4'h0, c1, c0, ei1, ei0}, 8'h0F ^ (8'h01 << (b - 2)));
        end
        // pin inputs need two sync stages: no change after a single edge
        ctrl_pull = 8'h00;
        tick(4);
        ctrl_pull = 8'h10;
        tick(1);
        check("sync early", {7'h00, c0}, 8'h01);
        tick(3);
        check("sync late", {7'h00, c0}, 8'h00);
        // serial port: receive input and transmit output
        ctrl_pull = 8'h01;
        u_txd = 1'b0;
        tick(4);
        check("uart rx tx", {6'h00, rxd, ctrl_lvl[1]}, 8'h00);
        ctrl_pull = 8'h00;
        u_m0 = 1'b1;
        u_data = 1'b0;
        tick(4);
        check("uart mode0 data", {7'h00, ctrl_lvl[0]}, 8'h00);
        u_m0 = 1'b0; u_data = 1'b1; u_txd = 1'b1;
        // external data access: address bytes and strobes
        x_act = 1'b1; x_mid = 8'h3C; x_high = 8'hA5; x_wr_n = 1'b0;
        tick(4);
        check("xdata mid", adrh_lvl, 8'h3C);
        check("xdata wr", {7'h00, ctrl_lvl[6]}, 8'h00);
        x_sel = 1'b1; x_wr_n = 1'b1; x_rd_n = 1'b0;
        tick(4);
        check("xdata high", adrh_lvl, 8'hA5);
        check("xdata rd", {ctrl_lvl[7], ctrl_lvl[6], 6'h00}, 8'h40);
        x_act = 1'b0; x_sel = 1'b0; x_rd_n = 1'b1;
        // pulse-width outputs override a zero latch on bits 5 and 6
        sfr_write(ADDR_ADRH_PORT, 8'h00, PLMX_OP_MOVE_WRITE, 3'h0);
        pw_sel = 1'b1; pw_a = 1'b1;
        tick(4);
        check("pw a", {6'h00, adrh_lvl[6:5]}, 8'h01);
        pw_a = 1'b0; pw_b = 1'b1;
        tick(4);
        check("pw b", {6'h00, adrh_lvl[6:5]}, 8'h02);
        pw_sel = 1'b0; pw_b = 1'b0;
        // pulse-width clock input and spi slave inputs from the pins
        sfr_write(ADDR_ADRH_PORT, 8'hFF, PLMX_OP_MOVE_WRITE, 3'h0);
        adrh_pull = 8'h80;
        tick(4);
        check("pw clock", {7'h00, pw_clk}, 8'h00);
        spi_en = 1'b1;
        adrh_pull = 8'h1B;
        tick(4);
        check("spi slave in", {3'h0, sclk, t2x, t2c, ss_n, mosi_in}, 8'h00);
        // spi master drives clock and data out, samples miso
        spi_m = 1'b1; spi_mosi = 1'b1; adrh_pull = 8'h04;
        tick(4);
        check("spi master", {4'h0, miso_in, adrh_lvl[2:0]}, 8'h02);
        conclude();
    end
endmodule
`default_nettype wire
